// file: rtl/cfi_interlock.sv
/*
  Coupler fault interlock: sticky fault flags, unsafe state and gated couple and
  uncouple outputs. Assumes all inputs synchronous to core_clk and that the
  pressure, short and processor checks are reported as level inputs.
*/
module cfi_interlock
  import cfi_pkg::*;
#(
  parameter int IDENT_CYCLES = cfi_pkg::IDENT_TIMEOUT_CYC
) (
  input  wire logic                        core_clk,          // Core clock, 200 MHz.
  input  wire logic                        rst,               // Power-on reset.
  input  wire logic                        coupleCmd,         // Host couple request.
  input  wire logic                        uncoupleCmd,       // Host uncouple request.
  input  wire logic                        faultClearCmd,     // Host fault-clear request.
  input  wire logic                        linkLost,          // Processors not talking.
  input  wire logic                        crossMismatch,     // Processors disagree.
  input  wire logic                        coupleShort,       // Couple output overload.
  input  wire logic                        valveAShort,       // Uncouple A overload.
  input  wire logic                        valveBShort,       // Uncouple B overload.
  input  wire logic                        lockSense,         // Lock position sensor.
  input  wire logic                        releaseSense,      // Release position sensor.
  input  wire logic                        pressAbove,        // Air above range.
  input  wire logic                        pressBelow,        // Air below range.
  input  wire logic                        pressDisconnected, // Pressure sensor absent.
  input  wire logic                        proximitySenseA,   // Proximity sensor A.
  input  wire logic                        proximitySenseB,   // Proximity sensor B.
  input  wire logic                        safetySwitchFault, // Safety switch fault.
  input  wire logic                        safetySwitchOk,    // Tool sits in the stand.
  input  wire logic                        logicSupplyPresent,// Logic supply present.
  input  wire logic                        outputSupplyOk,    // Output supply in range.
  input  wire logic                        contactDetect,     // Module contacts engaged.
  input  wire logic                        identReceived,     // Tool identity reported.
  input  wire logic                        valveMalfunction,  // Valve malfunction seen.
  output logic                             coupleOut,         // Couple valve drive.
  output logic                             uncoupleOut,       // Uncouple valve drive.
  output logic [cfi_pkg::FAULT_W-1:0]      faultFlags,        // Sticky fault flags.
  output logic                             unsafeState,       // Unsafe state.
  output logic                             healthyStatus      // No blocking fault.
);
  typedef enum logic [2:0] {
    CFI_IDLE     = 3'b001,
    CFI_COUPLE   = 3'b010,
    CFI_UNCOUPLE = 3'b100
  } cfi_mode_e;

  cfi_mode_e                mode;
  cfi_mode_e                next_mode;
  logic [FAULT_W-1:0]       next_faultFlags;
  logic                     next_unsafeState;
  logic                     next_coupleOut;
  logic                     next_uncoupleOut;
  logic                     next_healthy;
  logic                     startSeen;
  logic                     next_startSeen;
  logic [3:0]               rises;
  logic                     coupleRise;
  logic                     uncoupleRise;
  logic                     clearRise;
  logic                     contactRise;
  logic                     identExpired;
  logic                     coupleOk;
  logic                     uncoupleOk;
  logic [FAULT_W-1:0]       cond;
  logic [FAULT_W-1:0]       clearable;

  // Edge detection for the host requests and the contact input.
  cfi_edge_detect #(.W(4)) u_edges (
    .core_clk (core_clk),
    .rst      (rst),
    .level    ({contactDetect, faultClearCmd, uncoupleCmd, coupleCmd}),
    .rise     (rises)
  );
  assign coupleRise   = rises[0];
  assign uncoupleRise = rises[1];
  assign clearRise    = rises[2];
  assign contactRise  = rises[3];

  // Identity timeout from the moment of coupling.
  cfi_ident_timer #(.LIMIT(IDENT_CYCLES)) u_ident (
    .core_clk (core_clk),
    .rst      (rst),
    .coupled  (contactDetect & lockSense),
    .identOk  (identReceived),
    .expired  (identExpired)
  );

  // Preconditions for coupling and for uncoupling.
  always_comb begin
    coupleOk = !uncoupleCmd && logicSupplyPresent && !lockSense
               && !faultFlags[F_PRESS_HIGH] && !faultFlags[F_PRESS_LOW]
               && proximitySenseA && proximitySenseB && !unsafeState;
    uncoupleOk = healthyStatus && logicSupplyPresent && outputSupplyOk
                 && !pressAbove && !pressBelow && !coupleCmd
                 && safetySwitchOk && !safetySwitchFault;
  end

  // Present fault conditions and the flags a fault-clear may drop.
  always_comb begin
    cond                   = '0;
    cond[F_LINK]           = linkLost;
    cond[F_CROSS]          = crossMismatch;
    cond[F_COUPLE_SHORT]   = coupleShort;
    cond[F_VALVE_A_SHORT]  = valveAShort;
    cond[F_VALVE_B_SHORT]  = valveBShort;
    cond[F_POS_CONFLICT]   = lockSense && releaseSense;
    cond[F_PRESS_HIGH]     = pressAbove;
    cond[F_PRESS_LOW]      = pressBelow;
    cond[F_SWITCH]         = safetySwitchFault;
    cond[F_IDENT_TIMEOUT]  = identExpired;
    cond[F_VALVE]          = valveMalfunction;
    cond[F_PRESS_DISC]     = pressDisconnected;
    cond[F_PROX_MISMATCH]  = uncoupleRise && (proximitySenseA != proximitySenseB);
    cond[F_UNSAFE_COUPLE]  = coupleRise && !coupleOk;
    cond[F_UNSAFE_UNCPL]   = (uncoupleRise && !uncoupleOk)
                             || (!startSeen && uncoupleCmd);
    // Every flag accepts the fault-clear rise as well as power cycle.
    clearable = {FAULT_W{clearRise}};
  end

  // Sticky flag update; a present condition always wins over any clear.
  always_comb begin
    next_faultFlags = faultFlags;
    for (int i = 0; i < FAULT_W; i++) begin
      if (clearable[i]) begin
        next_faultFlags[i] = 1'b0;
      end
    end
    // Auto-clearing flags follow their conditions.
    if (!cond[F_POS_CONFLICT]) begin
      next_faultFlags[F_POS_CONFLICT] = 1'b0;
    end
    if (!pressAbove) begin
      next_faultFlags[F_PRESS_HIGH] = 1'b0;
    end
    if (!pressBelow) begin
      next_faultFlags[F_PRESS_LOW] = 1'b0;
    end
    if (uncoupleRise && proximitySenseA == proximitySenseB) begin
      next_faultFlags[F_PROX_MISMATCH] = 1'b0;
    end
    if (uncoupleRise && uncoupleOk) begin
      next_faultFlags[F_UNSAFE_UNCPL] = 1'b0;
    end
    if (coupleRise) begin
      next_faultFlags[F_UNSAFE_COUPLE] = 1'b0;
    end
    if (contactRise) begin
      next_faultFlags[F_IDENT_TIMEOUT] = 1'b0;
    end
    next_faultFlags = next_faultFlags | cond;
  end

  // Unsafe state: some flags always, some only while uncoupling.
  always_comb begin
    next_unsafeState = unsafeState;
    if (clearRise) begin
      next_unsafeState = 1'b0;
    end
    if ((next_faultFlags & UNSAFE_ALWAYS) != '0) begin
      next_unsafeState = 1'b1;
    end
    if (mode == CFI_UNCOUPLE && (next_faultFlags & UNSAFE_UNCPL) != '0) begin
      next_unsafeState = 1'b1;
    end
    next_healthy = ((next_faultFlags & BLOCKING_MASK) == '0)
                   && !next_unsafeState;
  end

  // Mode and output control; unsafe state freezes both valve drives except for the uncouple drops below.
  always_comb begin
    next_mode        = mode;
    next_coupleOut   = coupleOut;
    next_uncoupleOut = uncoupleOut;
    next_startSeen   = 1'b1;
    if (!unsafeState) begin
      case (mode)
        CFI_IDLE: begin
          if (coupleRise && coupleOk) begin
            next_mode      = CFI_COUPLE;
            next_coupleOut = 1'b1;
          end else if (uncoupleRise && uncoupleOk) begin
            next_mode        = CFI_UNCOUPLE;
            next_uncoupleOut = 1'b1;
          end
        end
        CFI_COUPLE: begin
          if (!coupleCmd) begin
            next_mode      = CFI_IDLE;
            next_coupleOut = 1'b0;
          end
        end
        CFI_UNCOUPLE: begin
          if (!uncoupleCmd) begin
            next_mode        = CFI_IDLE;
            next_uncoupleOut = 1'b0;
          end
        end
        default: begin
          next_mode        = CFI_IDLE;
          next_coupleOut   = 1'b0;
          next_uncoupleOut = 1'b0;
        end
      endcase
    end
    // Switch fault or unsafe uncouple request drop the uncouple drive at once.
    if (safetySwitchFault || (uncoupleRise && !uncoupleOk)) begin
      next_uncoupleOut = 1'b0;
      if (mode == CFI_UNCOUPLE) begin
        next_mode = CFI_IDLE;
      end
    end
  end

  // Register all control state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode          <= CFI_IDLE;
      faultFlags    <= FAULT_RESET;
      unsafeState   <= 1'b0;
      healthyStatus <= 1'b1;
      coupleOut     <= 1'b0;
      uncoupleOut   <= 1'b0;
      startSeen     <= 1'b0;
    end else begin
      mode          <= next_mode;
      faultFlags    <= next_faultFlags;
      unsafeState   <= next_unsafeState;
      healthyStatus <= next_healthy;
      coupleOut     <= next_coupleOut;
      uncoupleOut   <= next_uncoupleOut;
      startSeen     <= next_startSeen;
    end
  end
endmodule : cfi_interlock

// file: rtl/cfi_pkg.sv
/*
  Constants shared by the coupler fault interlock: fault flag positions and timing.
  Assumes a single 200 MHz core clock and an active-high asynchronous reset.
*/
// Behaviour
// - Processor link loss raises the link fault flag; power cycle clears it.
// - Processor disagreement on safety I/O raises the cross-check flag.
// - Couple output short or overload raises its flag; fault-clear clears it.
// - Separate short flags for uncouple outputs to valve A and valve B.
// - Position conflict flag follows lock and release sensors both active.
// - Over-pressure flag sets above range; clears on fault-clear or recovery.
// - Under-pressure flag sets below range; clears on fault-clear or recovery.
// - On uncouple command, differing proximity inputs set the mismatch flag.
// - Mismatch clears on new uncouple command without mismatch, or fault-clear.
// - Safety switch fault sets its flag and drops the uncouple output at once.
// - Identity missing 250 ms after coupling, or while coupled, sets timeout flag.
// - Identity timeout clears on contact-detect rise, power cycle or fault-clear.
// - Couple runs only with all couple preconditions met.
// - Couple request with unmet preconditions sets unsafe-couple flag.
// - Uncouple command with unmet preconditions sets flag and drops uncouple.
// - Uncouple command already high after power return sets unsafe-uncouple.
// - Unsafe-uncouple clears on re-applied safe command or fault-clear rise; the flag itself blocks uncouple, so only fault-clear clears it.
// - Valve malfunction sets valve flag and the unsafe state.
// - Unsafe state freezes both outputs bar switch-fault or unsafe uncouple drops; fault-clear clears it.
// - Link, cross, sensor, valve always unsafe; short, conflict, pressure in uncouple.
// - Link, cross, short, disconnect and valve flags also clear on fault-clear.
// - Healthy status is high only while no fault blocks an uncouple.
package cfi_pkg;
  localparam int FAULT_W          = 16;
  localparam int F_LINK           = 0;
  localparam int F_CROSS          = 1;
  localparam int F_COUPLE_SHORT   = 2;
  localparam int F_VALVE_A_SHORT  = 3;
  localparam int F_VALVE_B_SHORT  = 4;
  localparam int F_POS_CONFLICT   = 5;
  localparam int F_PRESS_HIGH     = 6;
  localparam int F_PRESS_LOW      = 7;
  localparam int F_PROX_MISMATCH  = 8;
  localparam int F_SWITCH         = 9;
  localparam int F_IDENT_TIMEOUT  = 10;
  localparam int F_UNSAFE_COUPLE  = 11;
  localparam int F_UNSAFE_UNCPL   = 12;
  localparam int F_VALVE          = 13;
  localparam int F_PRESS_DISC     = 14;
  localparam int F_SPARE          = 15;
  localparam logic [15:0] FAULT_RESET = 16'h0000;
  // Flags that always push the block into the unsafe state.
  localparam logic [15:0] UNSAFE_ALWAYS  = 16'h6003;
  // Flags that push the block into the unsafe state only while uncoupling.
  localparam logic [15:0] UNSAFE_UNCPL   = 16'h00FC;
  // Flags that block an uncouple request and drop the healthy status.
  localparam logic [15:0] BLOCKING_MASK  = 16'h72FF;
  localparam int CLK_MHZ          = 200;
  localparam int IDENT_TIMEOUT_MS = 250;
  localparam int IDENT_TIMEOUT_CYC = IDENT_TIMEOUT_MS * 1000 * CLK_MHZ;
endpackage : cfi_pkg

// file: rtl/cfi_edge_detect.sv
/*
  Rising edge detector for a group of synchronous request bits.
  Assumes inputs already synchronous to core_clk.
*/
module cfi_edge_detect #(
  parameter int W = 4
) (
  input  wire logic         core_clk, // Core clock.
  input  wire logic         rst,      // Asynchronous reset, active high.
  input  wire logic [W-1:0] level,    // Levels to watch.
  output logic      [W-1:0] rise      // One-cycle pulse on each rising edge.
);
  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  // Next value is simply the present level.
  always_comb begin
    next_prev = level;
  end

  // Previous value resets high so a level already high at release gives no edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= '1;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;
endmodule : cfi_edge_detect

// file: rtl/cfi_ident_timer.sv
/*
  Identity timer: counts core_clk cycles from coupling until identity arrives.
  Assumes contact and identity inputs synchronous to core_clk.
*/
module cfi_ident_timer #(
  parameter int LIMIT = 50000000
) (
  input  wire logic core_clk,  // Core clock.
  input  wire logic rst,       // Asynchronous reset, active high.
  input  wire logic coupled,   // Master and tool are coupled.
  input  wire logic identOk,   // Tool identity has been received.
  output logic      expired    // Level: coupled too long without identity.
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_expired;

  // Count while coupled without identity; saturate when the limit is reached.
  always_comb begin
    next_count   = count;
    next_expired = expired;
    if (!coupled || identOk) begin
      next_count   = 32'h00000000;
      next_expired = 1'b0;
    end else if (count >= 32'(LIMIT - 1)) begin
      next_expired = 1'b1;
    end else begin
      next_count = count + 32'h00000001;
    end
  end

  // Register the count and the expiry level.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count   <= 32'h00000000;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end
endmodule : cfi_ident_timer

// file: tb/cfi_host_model.sv
/*
  Host controller model: turns bench requests into host command levels.
  Assumes the bench changes its requests at the falling edge of core_clk.
*/
module cfi_host_model (
  input  wire logic core_clk,      // Core clock.
  input  wire logic wantCouple,    // Bench asks for couple.
  input  wire logic wantUncouple,  // Bench asks for uncouple.
  input  wire logic wantClear,     // Bench asks for fault clear.
  output logic      coupleCmd,     // Couple request level.
  output logic      uncoupleCmd,   // Uncouple request level.
  output logic      faultClearCmd  // Fault-clear request level.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Commands follow the bench one falling edge later, away from the sampling edge.
  always @(negedge core_clk) begin
    {coupleCmd, uncoupleCmd, faultClearCmd} <= {wantCouple, wantUncouple, wantClear};
  end
endmodule : cfi_host_model

// file: tb/cfi_interlock_assertions.sv
/*
  Checker for the interlock: timing relations between its ports.
  Assumes one core_clk domain and the active-high asynchronous rst.
*/
module cfi_interlock_assertions
  import cfi_pkg::*;
(
  input wire logic               core_clk,           // Core clock.
  input wire logic               rst,                // Reset.
  input wire logic               coupleCmd,          // Couple request.
  input wire logic               uncoupleCmd,        // Uncouple request.
  input wire logic               linkLost,           // Link loss.
  input wire logic               pressAbove,         // Air too high.
  input wire logic               pressBelow,         // Air too low.
  input wire logic               pressDisconnected,  // Sensor absent.
  input wire logic               lockSense,          // Lock sensor.
  input wire logic               releaseSense,       // Release sensor.
  input wire logic               proximitySenseA,    // Proximity A.
  input wire logic               proximitySenseB,    // Proximity B.
  input wire logic               safetySwitchFault,  // Switch fault.
  input wire logic               safetySwitchOk,     // In the stand.
  input wire logic               logicSupplyPresent, // Logic supply.
  input wire logic               valveMalfunction,   // Valve fault.
  input wire logic               coupleOut,          // Couple drive.
  input wire logic               uncoupleOut,        // Uncouple drive.
  input wire logic [FAULT_W-1:0] faultFlags,         // Fault flags.
  input wire logic               unsafeState,        // Unsafe state.
  input wire logic               healthyStatus       // Healthy status.
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the core clock and stop while reset is high.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_LINK_UNSAFE: assert property (
    linkLost |-> ##[1:2] (faultFlags[F_LINK] && unsafeState))
    else $error("link loss did not raise flag and unsafe state");
  AST_VALVE_UNSAFE: assert property (
    valveMalfunction |-> ##[1:2] (faultFlags[F_VALVE] && unsafeState))
    else $error("valve fault did not raise flag and unsafe state");
  AST_DISC_UNSAFE: assert property (
    pressDisconnected |-> ##[1:2] (faultFlags[F_PRESS_DISC] && unsafeState))
    else $error("sensor loss did not raise flag and unsafe state");
  AST_CONFLICT_SET: assert property (
    lockSense && releaseSense |=> faultFlags[F_POS_CONFLICT])
    else $error("position conflict flag missing");
  AST_CONFLICT_DROP: assert property (
    !(lockSense && releaseSense) [*2] |-> !faultFlags[F_POS_CONFLICT])
    else $error("position conflict flag stuck");
  AST_SWITCH_DROP: assert property (
    safetySwitchFault |=> !uncoupleOut && faultFlags[F_SWITCH])
    else $error("switch fault left uncouple driven");
  AST_COUPLE_REFUSE: assert property (
    $rose(coupleCmd) && lockSense |-> ##[1:2] faultFlags[F_UNSAFE_COUPLE])
    else $error("unsafe couple not flagged");
  AST_COUPLE_GO: assert property (
    $rose(coupleCmd) && !uncoupleCmd && logicSupplyPresent && !lockSense
    && proximitySenseA && proximitySenseB && !pressAbove && !pressBelow
    && !faultFlags[F_PRESS_HIGH] && !faultFlags[F_PRESS_LOW] && !unsafeState
    |-> ##[1:2] coupleOut)
    else $error("safe couple not carried out");
  AST_UNCPL_REFUSE: assert property (
    $rose(uncoupleCmd) && !safetySwitchOk
    |-> ##[1:2] (faultFlags[F_UNSAFE_UNCPL] && !uncoupleOut))
    else $error("unsafe uncouple not refused");
  AST_PROX_MISMATCH: assert property (
    $rose(uncoupleCmd) && (proximitySenseA != proximitySenseB)
    |-> ##[1:2] faultFlags[F_PROX_MISMATCH])
    else $error("proximity mismatch not flagged");
  AST_FREEZE: assert property (
    unsafeState ##1 unsafeState |-> $stable(coupleOut))
    else $error("couple drive moved while unsafe");
  AST_HEALTHY: assert property (
    (|(faultFlags & BLOCKING_MASK)) [*2] |-> !healthyStatus)
    else $error("healthy status high with a blocking flag");
endmodule : cfi_interlock_assertions

bind cfi_interlock cfi_interlock_assertions chk_u (.*);

// file: tb/coupler_fault_interlock_bench.sv
/*
  Self-checking bench for the interlock, one task per scenario.
  Assumes the host model delays each request by one clock cycle.
*/
module coupler_fault_interlock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfi_pkg::*;
  localparam int IDENT = 20;
  localparam int SRC_BIT [9] = '{F_LINK, F_CROSS, F_COUPLE_SHORT, F_VALVE_A_SHORT,
                                 F_VALVE_B_SHORT, F_PRESS_HIGH, F_PRESS_LOW, F_PRESS_DISC, F_VALVE};
  logic core_clk, rst, wantCouple, wantUncouple, wantClear, coupleCmd, uncoupleCmd;
  logic faultClearCmd, lockSense, releaseSense, proximitySenseA, proximitySenseB;
  logic safetySwitchFault, safetySwitchOk, logicSupplyPresent, outputSupplyOk, contactDetect;
  logic linkLost, crossMismatch, coupleShort, valveAShort, valveBShort, pressAbove, pressBelow;
  logic pressDisconnected, valveMalfunction, identReceived, coupleOut, uncoupleOut;
  logic unsafeState, healthyStatus;
  logic [FAULT_W-1:0] faultFlags;
  logic [8:0]         src;
  int                 failCount;
  int                 checked;
  // Level fault sources come from one vector so a table can walk them.
  assign {valveMalfunction, pressDisconnected, pressBelow, pressAbove, valveBShort,
          valveAShort, coupleShort, crossMismatch, linkLost} = src;
  cfi_host_model host_u (.*);
  cfi_interlock #(.IDENT_CYCLES(IDENT)) dut_u (.*);
  // Clock of 5 ns period.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step
  function automatic logic [19:0] st();
    return {faultFlags, unsafeState, healthyStatus, coupleOut, uncoupleOut};
  endfunction : st
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic clr();
    wantClear <= 1'b1;
    step(2);
    wantClear <= 1'b0;
    step(3);
  endtask : clr
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : completeRun
  // Each level fault sets its own flag, unsafe per mask, and clears on request.
  task automatic testFaults();
    logic [15:0] f;
    logic [19:0] e;
    for (int k = 0; k < 9; k++) begin
      f = 16'h0001 << SRC_BIT[k];
      e = {f, UNSAFE_ALWAYS[SRC_BIT[k]], ~BLOCKING_MASK[SRC_BIT[k]], 2'b00};
      src[k] <= 1'b1;
      step(3);
      chk(st(), e);
      chk(20'(faultFlags), 20'(f));
      src <= '0;
      clr();
      chk(st(), {16'h0000, 4'b0100});
    end
    $display("fault table done");
  endtask : testFaults
  // Safe couple, freeze while unsafe, refused couple and its re-request.
  task automatic testCouple();
    wantCouple <= 1'b1;
    step(3);
    chk(st(), {16'h0000, 4'b0110});
    src[0] <= 1'b1;
    step(1);
    src[0] <= 1'b0;
    wantCouple <= 1'b0;
    step(4);
    chk(st(), {16'h0001, 4'b1010});
    clr();
    chk(st(), {16'h0000, 4'b0100});
    lockSense <= 1'b1;
    wantCouple <= 1'b1;
    step(3);
    chk(st(), {16'h0800, 4'b0100});
    wantCouple <= 1'b0;
    lockSense <= 1'b0;
    step(2);
    wantCouple <= 1'b1;
    step(3);
    chk(st(), {16'h0000, 4'b0110});
    wantCouple <= 1'b0;
    step(3);
    $display("couple done");
  endtask : testCouple
  // Both position sensors active, then one released.
  task automatic testConflict();
    {lockSense, releaseSense} <= 2'b11;
    step(3);
    chk(st(), {16'h0020, 4'b0000});
    {lockSense, releaseSense} <= 2'b10;
    step(3);
    chk(st(), {16'h0000, 4'b0100});
    lockSense <= 1'b0;
    $display("conflict done");
  endtask : testConflict
  // Safe uncouple, then a switch fault drops it; then mismatch and refusal.
  task automatic testUncouple();
    safetySwitchOk <= 1'b1;
    wantUncouple <= 1'b1;
    step(3);
    chk(st(), {16'h0000, 4'b0101});
    // Over-pressure while uncoupling makes the block unsafe and freezes the drive.
    src[5] <= 1'b1;
    step(2);
    chk(st(), {16'h0040, 4'b1001});
    src[5] <= 1'b0;
    safetySwitchFault <= 1'b1;
    step(2);
    chk(st(), {16'h0200, 4'b1000});
    safetySwitchFault <= 1'b0;
    wantUncouple <= 1'b0;
    clr();
    chk(st(), {16'h0000, 4'b0100});
    safetySwitchOk <= 1'b0;
    proximitySenseB <= 1'b0;
    wantUncouple <= 1'b1;
    step(3);
    chk(st(), {16'h1100, 4'b0000});
    wantUncouple <= 1'b0;
    proximitySenseB <= 1'b1;
    step(2);
    wantUncouple <= 1'b1;
    step(3);
    chk(st(), {16'h1000, 4'b0000});
    clr();
    chk(st(), {16'h0000, 4'b0100});
    wantUncouple <= 1'b0;
    step(2);
    $display("uncouple done");
  endtask : testUncouple
  // Identity missing while coupled, cleared by a new contact, then supplied.
  task automatic testIdent();
    int n;
    contactDetect <= 1'b1;
    lockSense <= 1'b1;
    n = 0;
    while (faultFlags[F_IDENT_TIMEOUT] !== 1'b1 && n < 4 * IDENT) begin
      step(1);
      n++;
    end
    chk({19'h0, n >= IDENT - 1 && n <= IDENT + 3}, 20'h00001);
    if (n >= 4 * IDENT) begin
      completeRun();
    end
    chk(st(), {16'h0400, 4'b0100});
    contactDetect <= 1'b0;
    step(2);
    contactDetect <= 1'b1;
    step(3);
    chk(st(), {16'h0000, 4'b0100});
    identReceived <= 1'b1;
    step(IDENT + 5);
    chk(st(), {16'h0000, 4'b0100});
    {contactDetect, lockSense} <= 2'b00;
    $display("identity done");
  endtask : testIdent
  // Mid-run reset with the uncouple request held high.
  task automatic testPowerOn();
    wantUncouple <= 1'b1;
    step(3);
    rst <= 1'b1;
    step(2);
    chk(st(), {16'h0000, 4'b0100});
    rst <= 1'b0;
    step(3);
    chk(st(), {16'h1000, 4'b0000});
    wantUncouple <= 1'b0;
    clr();
    chk(st(), {16'h0000, 4'b0100});
    $display("power-on done");
  endtask : testPowerOn
  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    rst = 1'b1;
    src = '0;
    failCount = 0;
    checked = 0;
    {wantCouple, wantUncouple, wantClear, lockSense, releaseSense} = 5'h00;
    {safetySwitchFault, safetySwitchOk, contactDetect, identReceived} = 4'h0;
    {proximitySenseA, proximitySenseB, logicSupplyPresent, outputSupplyOk} = 4'hF;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst <= 1'b0;
    step(2);
    chk(st(), {16'h0000, 4'b0100});
    testFaults();
    testCouple();
    testConflict();
    testUncouple();
    testIdent();
    testPowerOn();
    completeRun();
  end
endmodule : coupler_fault_interlock_bench
